// *** common/dscifd_pkg.sv ***
// Purpose: shared constants and types of the instruction format decoder
// Assumes: 24-bit instruction words, opcode in the top byte
// Notes: opcode ranges and operand bit positions are fixed here and nowhere else
package dscifd_pkg;

    localparam int INSN_W = 24;
    localparam int OPC_W = 8;
    localparam int OPC_LSB = 16;
    localparam int FILE_W = 13;

    // opcode ranges, upper bounds exclusive
    localparam logic [7:0] OPC_LIT_MOVE_LO = 8'h10;
    localparam logic [7:0] OPC_LIT_ARITH_LO = 8'h20;
    localparam logic [7:0] OPC_DEFAULT_WORK_REG_LO = 8'h40;
    localparam logic [7:0] OPC_FILE_LO = 8'h80;
    localparam logic [7:0] OPC_BIT_LO = 8'hA0;
    localparam logic [7:0] OPC_MAC_LO = 8'hC0;
    localparam logic [7:0] OPC_MAC_HI = 8'hD0;
    localparam logic [7:0] OPC_NOP = 8'h00;
    localparam logic [7:0] OPC_TWO_WORD_0 = 8'h02;
    localparam logic [7:0] OPC_TWO_WORD_1 = 8'h04;
    localparam logic [7:0] OPC_TWO_WORD_2 = 8'h06;
    localparam logic [7:0] SECOND_WORD_TOP = 8'h00;

    // working register operand positions
    localparam int BASE_LSB = 12;
    localparam int DMODE_LSB = 10;
    localparam int DREG_LSB = 6;
    localparam int SMODE_LSB = 4;
    localparam int SREG_LSB = 0;
    // file register operand positions
    localparam int FDEST_BIT = 13;
    localparam int FADDR_LSB = 0;
    // bit operand positions
    localparam int BITPOS_LSB = 12;
    localparam int BITREG_FLAG = 11;
    localparam int BITFILE_FLAG = 10;
    localparam int BITFILE_W = 10;
    // literal operand positions
    localparam int LMOVE_LIT_LSB = 4;
    localparam int LMOVE_LIT_W = 12;
    localparam int LFILE_LIT_LSB = 8;
    localparam int LFILE_ADDR_W = 8;
    localparam int LARITH_LIT_LSB = 6;
    localparam int LARITH_LIT_W = 6;
    localparam int OPC_VARIANT_BIT = 0;
    // multiply-accumulate operand positions
    localparam int MAC_ACC_BIT = 15;
    localparam int MAC_PAIR_LSB = 12;
    localparam int MAC_XOP_LSB = 10;
    localparam int MAC_XDST_LSB = 8;
    localparam int MAC_YOP_LSB = 6;
    localparam int MAC_YDST_LSB = 4;
    localparam int MAC_AWB_LSB = 2;

    localparam logic [3:0] DEFAULT_WORK_REG = 4'h0;

    typedef enum logic [2:0] {
        DSCIFD_CAT_WORD_BYTE,
        DSCIFD_CAT_BIT,
        DSCIFD_CAT_LITERAL,
        DSCIFD_CAT_DSP,
        DSCIFD_CAT_CONTROL
    } dscifd_cat_t;

    typedef struct packed {
        dscifd_cat_t cat;
        logic [7:0] opcode;
        logic [3:0] base_work_reg;
        logic [3:0] source_work_reg;
        logic [1:0] src_mode;
        logic [3:0] dest_work_reg;
        logic [1:0] dest_mode;
        logic [12:0] file_addr;
        logic dest_is_file;
        logic [3:0] bit_pos;
        logic bit_from_reg;
        logic target_is_file;
        logic [15:0] literal;
        logic acc_sel;
        logic [2:0] mul_pair;
        logic [1:0] x_op;
        logic [1:0] x_dst;
        logic [1:0] y_op;
        logic [1:0] y_dst;
        logic [1:0] awb;
    } dscifd_fields_t;

endpackage

// *** design/dscifd_decoder.sv ***
// Purpose: instruction format decoder between fetch and execute
// Assumes: fetch presents one 24-bit word per accepted cycle; execute flags redirects
// Notes: every output is registered; all fields of one instruction leave together
//
// Overview of operation
// RQ1: an ordinary instruction is exactly one 24-bit program word.
// RQ2: three fixed opcodes take two consecutive words; both are collected first.
// RQ3: a single word splits into an 8-bit opcode and operand bits.
// RQ4: every opcode falls into exactly one of five categories.
// RQ5: working register ops give base, modified source and modified destination.
// RQ6: file register ops give the address and a file or default register destination.
// RQ7: bit ops give a register or file target and a literal or register bit number.
// RQ8: literal moves give the literal and a base register or file target.
// RQ9: literal arithmetic uses base register and literal; separate destination optional.
// RQ10: multiply-accumulate gives accumulator, register pair, prefetches and write-back.
// RQ11: a second word has a zero top byte and runs as no-op alone.
// RQ12: one cycle per word; a taken test or redirect adds one no-op cycle.
// RQ13: category, opcode and all operand fields are valid in the same cycle.
`timescale 1ns/1ns
module dscifd_decoder
    import dscifd_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic fetch_valid,
    input wire logic [23:0] fetch_word,
    output logic fetch_ready,
    input wire logic exec_redirect,
    output logic dec_valid,
    output logic dec_nop,
    output logic dec_two_word,
    output logic dec_second_bad,
    output logic [15:0] dec_ext_word,
    output dscifd_cat_t dec_cat,
    output logic [7:0] dec_opcode,
    output logic [3:0] base_work_reg,
    output logic [3:0] source_work_reg,
    output logic [1:0] dec_src_mode,
    output logic [3:0] dest_work_reg,
    output logic [1:0] dec_dest_mode,
    output logic [12:0] dec_file_addr,
    output logic dec_dest_is_file,
    output logic [3:0] dec_bit_pos,
    output logic dec_bit_from_reg,
    output logic dec_target_is_file,
    output logic [15:0] dec_literal,
    output logic dec_acc_sel,
    output logic [2:0] dec_mul_pair,
    output logic [1:0] dec_x_op,
    output logic [1:0] dec_x_dst,
    output logic [1:0] dec_y_op,
    output logic [1:0] dec_y_dst,
    output logic [1:0] dec_awb
);

    // two-word pairs and the redirect bubble are the only multi-cycle cases
    typedef enum logic [1:0] {
        DSCIFD_ST_FIRST,
        DSCIFD_ST_SECOND,
        DSCIFD_ST_BUBBLE
    } dscifd_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // operand extraction

    dscifd_state_t state_r, state_nxt;
    logic [23:0] held_r, held_nxt;
    logic [23:0] ext_in;
    dscifd_fields_t ext_fields;

    // while waiting for the second word the first one is decoded from the holding register
    assign ext_in = (state_r == DSCIFD_ST_SECOND) ? held_r : fetch_word;

    dscifd_extract u_extract (
        .insn(ext_in),
        .fields(ext_fields)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencing

    logic take;
    logic is_two_word;
    logic [2:0] two_hit;
    localparam logic [7:0] TWO_WORD_OPC [3] = '{OPC_TWO_WORD_0, OPC_TWO_WORD_1, OPC_TWO_WORD_2};
    logic ready_r, ready_nxt;
    logic valid_r, valid_nxt;
    logic nop_r, nop_nxt;
    logic two_r, two_nxt;
    logic bad_r, bad_nxt;
    logic [15:0] ext_word_r, ext_word_nxt;
    dscifd_fields_t fld_r, fld_nxt;

    // a word counts as taken only while the registered ready is high
    assign take = fetch_valid && ready_r;

    // one comparator per two-word opcode
    for (genvar i = 0; i < 3; i++) begin : g_two_word
        assign two_hit[i] = (fetch_word[OPC_LSB +: OPC_W] == TWO_WORD_OPC[i]);  // RQ2
    end
    assign is_two_word = |two_hit;  // RQ2

    always_comb begin
        state_nxt = state_r;
        held_nxt = held_r;
        ready_nxt = 1'b1;
        valid_nxt = 1'b0;
        nop_nxt = 1'b0;
        two_nxt = 1'b0;
        bad_nxt = 1'b0;
        ext_word_nxt = ext_word_r;
        fld_nxt = fld_r;
        if (exec_redirect) begin
            // the word in flight belongs to the abandoned path, so it is dropped
            state_nxt = DSCIFD_ST_BUBBLE;  // RQ12
            ready_nxt = 1'b0;  // RQ12
        end else begin
            unique case (state_r)
                DSCIFD_ST_FIRST: begin
                    if (take && is_two_word) begin
                        // the first half is parked until its partner arrives
                        held_nxt = fetch_word;  // RQ2
                        state_nxt = DSCIFD_ST_SECOND;  // RQ2
                    end else if (take) begin
                        valid_nxt = 1'b1;  // RQ1
                        fld_nxt = ext_fields;  // RQ13
                        ext_word_nxt = 16'h0000;
                        // a lone second word has a zero opcode and runs as a no-op
                        nop_nxt = (fetch_word[OPC_LSB +: OPC_W] == OPC_NOP);  // RQ11
                    end
                end
                DSCIFD_ST_SECOND: begin
                    if (take) begin
                        valid_nxt = 1'b1;  // RQ2
                        two_nxt = 1'b1;  // RQ2
                        fld_nxt = ext_fields;  // RQ13
                        ext_word_nxt = fetch_word[15:0];  // RQ2
                        // a malformed second word is still paired, only flagged
                        bad_nxt = (fetch_word[OPC_LSB +: OPC_W] != SECOND_WORD_TOP);  // RQ11
                        // the held half is spent; clearing it keeps stale bits off the extractor
                        held_nxt = 24'h000000;
                        state_nxt = DSCIFD_ST_FIRST;
                    end
                end
                DSCIFD_ST_BUBBLE: begin
                    // ready_r is low here, so no word can be taken during the bubble
                    valid_nxt = 1'b1;  // RQ12
                    nop_nxt = 1'b1;  // RQ12
                    // clean fields so execute never acts on a stale operand
                    fld_nxt = '0;
                    fld_nxt.cat = DSCIFD_CAT_CONTROL;
                    fld_nxt.opcode = OPC_NOP;
                    ext_word_nxt = 16'h0000;
                    state_nxt = DSCIFD_ST_FIRST;
                end
                default: begin
                    // an unused state code recovers to a clean first-word wait
                    state_nxt = DSCIFD_ST_FIRST;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= DSCIFD_ST_FIRST;
            held_r <= 24'h000000;
            ready_r <= 1'b1;
            valid_r <= 1'b0;
            nop_r <= 1'b0;
            two_r <= 1'b0;
            bad_r <= 1'b0;
            ext_word_r <= 16'h0000;
            fld_r <= '0;
        end else begin
            state_r <= state_nxt;
            held_r <= held_nxt;
            ready_r <= ready_nxt;
            valid_r <= valid_nxt;
            nop_r <= nop_nxt;
            two_r <= two_nxt;
            bad_r <= bad_nxt;
            ext_word_r <= ext_word_nxt;
            fld_r <= fld_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all taken from the same register stage

    // fetch_ready drops for exactly one cycle after a redirect
    assign fetch_ready = ready_r;
    assign dec_valid = valid_r;  // RQ13
    assign dec_nop = nop_r;
    assign dec_two_word = two_r;
    assign dec_second_bad = bad_r;
    assign dec_ext_word = ext_word_r;
    assign dec_cat = fld_r.cat;
    assign dec_opcode = fld_r.opcode;
    assign base_work_reg = fld_r.base_work_reg;
    assign source_work_reg = fld_r.source_work_reg;
    assign dec_src_mode = fld_r.src_mode;
    assign dest_work_reg = fld_r.dest_work_reg;
    assign dec_dest_mode = fld_r.dest_mode;
    assign dec_file_addr = fld_r.file_addr;
    assign dec_dest_is_file = fld_r.dest_is_file;
    assign dec_bit_pos = fld_r.bit_pos;
    assign dec_bit_from_reg = fld_r.bit_from_reg;
    assign dec_target_is_file = fld_r.target_is_file;
    assign dec_literal = fld_r.literal;
    assign dec_acc_sel = fld_r.acc_sel;
    assign dec_mul_pair = fld_r.mul_pair;
    assign dec_x_op = fld_r.x_op;
    assign dec_x_dst = fld_r.x_dst;
    assign dec_y_op = fld_r.y_op;
    assign dec_y_dst = fld_r.y_dst;
    assign dec_awb = fld_r.awb;

endmodule

// *** design/dscifd_extract.sv ***
// Purpose: pure combinational split of one instruction word into category and operands
// Assumes: opcode ranges and field positions from the package
// Notes: fields that a category does not use read as zero
`timescale 1ns/1ns
module dscifd_extract
    import dscifd_pkg::*;
(
    input wire logic [23:0] insn,
    output dscifd_fields_t fields
);

    logic [7:0] opc;
    logic [15:0] opd;

    assign opc = insn[OPC_LSB +: OPC_W];  // RQ3
    assign opd = insn[15:0];

    always_comb begin
        fields = '0;
        fields.opcode = opc;
        if (opc >= OPC_MAC_LO && opc < OPC_MAC_HI) begin
            fields.cat = DSCIFD_CAT_DSP;  // RQ4
            fields.acc_sel = opd[MAC_ACC_BIT];  // RQ10
            fields.mul_pair = opd[MAC_PAIR_LSB +: 3];  // RQ10
            fields.x_op = opd[MAC_XOP_LSB +: 2];  // RQ10
            fields.x_dst = opd[MAC_XDST_LSB +: 2];  // RQ10
            fields.y_op = opd[MAC_YOP_LSB +: 2];  // RQ10
            fields.y_dst = opd[MAC_YDST_LSB +: 2];  // RQ10
            fields.awb = opd[MAC_AWB_LSB +: 2];  // RQ10
        end else if (opc >= OPC_BIT_LO && opc < OPC_MAC_LO) begin
            fields.cat = DSCIFD_CAT_BIT;  // RQ4
            fields.bit_from_reg = opd[BITREG_FLAG];  // RQ7
            fields.target_is_file = opd[BITFILE_FLAG];  // RQ7
            if (opd[BITREG_FLAG]) begin
                fields.base_work_reg = opd[BITPOS_LSB +: 4];  // RQ7
            end else begin
                fields.bit_pos = opd[BITPOS_LSB +: 4];  // RQ7
            end
            if (opd[BITFILE_FLAG]) begin
                fields.file_addr = {3'h0, opd[BITFILE_W-1:0]};  // RQ7
            end else begin
                fields.src_mode = opd[SMODE_LSB +: 2];  // RQ7
                fields.source_work_reg = opd[SREG_LSB +: 4];  // RQ7
            end
        end else if (opc >= OPC_FILE_LO && opc < OPC_BIT_LO) begin
            fields.cat = DSCIFD_CAT_WORD_BYTE;  // RQ4
            fields.file_addr = opd[FADDR_LSB +: FILE_W];  // RQ6
            fields.dest_is_file = opd[FDEST_BIT];  // RQ6
            fields.target_is_file = 1'b1;
            // a cleared select writes the result to the default working register
            fields.dest_work_reg = DEFAULT_WORK_REG;  // RQ6
        end else if (opc >= OPC_DEFAULT_WORK_REG_LO && opc < OPC_FILE_LO) begin
            fields.cat = DSCIFD_CAT_WORD_BYTE;  // RQ4
            fields.base_work_reg = opd[BASE_LSB +: 4];  // RQ5
            fields.dest_mode = opd[DMODE_LSB +: 2];  // RQ5
            fields.dest_work_reg = opd[DREG_LSB +: 4];  // RQ5
            fields.src_mode = opd[SMODE_LSB +: 2];  // RQ5
            fields.source_work_reg = opd[SREG_LSB +: 4];  // RQ5
        end else if (opc >= OPC_LIT_ARITH_LO && opc < OPC_DEFAULT_WORK_REG_LO) begin
            fields.cat = DSCIFD_CAT_LITERAL;  // RQ4
            fields.base_work_reg = opd[BASE_LSB +: 4];  // RQ9
            fields.literal = {10'h000, opd[LARITH_LIT_LSB +: LARITH_LIT_W]};  // RQ9
            if (opc[OPC_VARIANT_BIT]) begin
                fields.dest_mode = opd[SMODE_LSB +: 2];  // RQ9
                fields.dest_work_reg = opd[SREG_LSB +: 4];  // RQ9
            end else begin
                // result goes back to the first source
                fields.dest_work_reg = opd[BASE_LSB +: 4];  // RQ9
            end
        end else if (opc >= OPC_LIT_MOVE_LO && opc < OPC_LIT_ARITH_LO) begin
            fields.cat = DSCIFD_CAT_LITERAL;  // RQ4
            fields.target_is_file = opc[OPC_VARIANT_BIT];  // RQ8
            if (opc[OPC_VARIANT_BIT]) begin
                fields.literal = {8'h00, opd[LFILE_LIT_LSB +: 8]};  // RQ8
                fields.file_addr = {5'h00, opd[LFILE_ADDR_W-1:0]};  // RQ8
            end else begin
                fields.literal = {4'h0, opd[LMOVE_LIT_LSB +: LMOVE_LIT_W]};  // RQ8
                fields.base_work_reg = opd[SREG_LSB +: 4];  // RQ8
            end
        end else begin
            fields.cat = DSCIFD_CAT_CONTROL;  // RQ4
            fields.literal = opd;
        end
    end

endmodule

// *** tb/dscifd_decoder_assertions.sv ***
// Purpose: concurrent checks on the decoder ports
// Assumes: one clock domain, asynchronous reset active high
// Notes: held_r mirrors whether the first word of a pair is waiting for its partner
`timescale 1ns/1ns
module dscifd_decoder_assertions
    import dscifd_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic fetch_valid,
    input wire logic [23:0] fetch_word,
    input wire logic fetch_ready,
    input wire logic exec_redirect,
    input wire logic dec_valid,
    input wire logic dec_nop,
    input wire logic dec_two_word,
    input wire logic dec_second_bad,
    input wire logic [15:0] dec_ext_word,
    input wire dscifd_cat_t dec_cat,
    input wire logic [7:0] dec_opcode,
    input wire logic [15:0] dec_literal
);
    ////////////////////////////////////////////////////////////////////////////////
    logic take;
    logic is_two;
    logic held_r;
    logic held_nxt;
    dscifd_cat_t exp_cat;
    assign take = fetch_valid && fetch_ready && !exec_redirect;
    assign is_two = fetch_word[23:16] inside {OPC_TWO_WORD_0, OPC_TWO_WORD_1, OPC_TWO_WORD_2};
    always_comb begin
        held_nxt = held_r;
        if (exec_redirect) begin
            held_nxt = 1'b0;
        end else if (take) begin
            held_nxt = !held_r && is_two;
        end
        if (fetch_word[23:16] < OPC_LIT_MOVE_LO || fetch_word[23:16] >= OPC_MAC_HI) begin
            exp_cat = DSCIFD_CAT_CONTROL;
        end else if (fetch_word[23:16] < OPC_DEFAULT_WORK_REG_LO) begin
            exp_cat = DSCIFD_CAT_LITERAL;
        end else if (fetch_word[23:16] < OPC_BIT_LO) begin
            exp_cat = DSCIFD_CAT_WORD_BYTE;
        end else if (fetch_word[23:16] < OPC_MAC_LO) begin
            exp_cat = DSCIFD_CAT_BIT;
        end else begin
            exp_cat = DSCIFD_CAT_DSP;
        end
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            held_r <= 1'b0;
        end else begin
            held_r <= held_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_redirect_bubble: assert property (exec_redirect ##1 !exec_redirect |-> (!fetch_ready && !dec_valid) ##1
        (dec_valid && dec_nop && dec_cat == DSCIFD_CAT_CONTROL && dec_opcode == OPC_NOP))
        else $error("no bubble after redirect");
    a_ready_restored: assert property (!exec_redirect |=> fetch_ready)
        else $error("fetch_ready low without redirect");
    a_single_word_out: assert property (take && (held_r || !is_two) |=> dec_valid)
        else $error("word taken but nothing decoded");
    a_first_word_quiet: assert property (take && !held_r && is_two |=> !dec_valid)
        else $error("first word of pair decoded alone");
    a_opcode_category: assert property (take && !held_r && !is_two |=>
        dec_opcode == $past(fetch_word[23:16]) && dec_cat == $past(exp_cat)) else $error("opcode or category wrong");
    a_pair_complete: assert property (take && held_r |=> dec_two_word && dec_ext_word == $past(fetch_word[15:0])
        && dec_second_bad == ($past(fetch_word[23:16]) != SECOND_WORD_TOP)) else $error("pair completion wrong");
    a_lone_second_nop: assert property (take && !held_r && fetch_word[23:16] == OPC_NOP |=>
        dec_nop && dec_cat == DSCIFD_CAT_CONTROL) else $error("lone zero word not a no-op");
    a_fields_hold: assert property (!dec_valid |-> $stable(dec_opcode) && $stable(dec_literal)
        && $stable(dec_cat) && $stable(dec_ext_word)) else $error("fields moved without dec_valid");
    a_flags_with_valid: assert property (!dec_valid |-> !dec_nop && !dec_two_word && !dec_second_bad)
        else $error("flag without dec_valid");
    c_redirect: cover property (exec_redirect);
    c_pair: cover property (take && held_r);
    c_lone_zero: cover property (take && !held_r && fetch_word[23:16] == OPC_NOP);
endmodule

// *** tb/dscifd_fetch_model.sv ***
// Purpose: program memory fetch path feeding the decoder
// Assumes: words pushed by the bench between clock edges, at most 64 in a run
// Notes: a word offered while fetch_ready is high is consumed; a redirect drops it like a branch
`timescale 1ns/1ns
module dscifd_fetch_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic fetch_ready,
    output logic fetch_valid,
    output logic [23:0] fetch_word
);
    logic [23:0] mem [0:63];
    int wr_ptr = 0;
    int rd_ptr;
    int rd_nxt;
    logic go;
    task automatic push(input logic [23:0] w);
        mem[wr_ptr] = w;
        wr_ptr = wr_ptr + 1;
    endtask
    always_comb begin
        rd_nxt = rd_ptr + ((fetch_valid && fetch_ready) ? 1 : 0);
        // an offered word is never withdrawn by a stall
        go = (run || (fetch_valid && !fetch_ready)) && rd_nxt < wr_ptr;
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_ptr <= 0;
            fetch_valid <= 1'b0;
            fetch_word <= 24'h5A5A5A;
        end else begin
            rd_ptr <= rd_nxt;
            fetch_valid <= go;
            // idle bus toggles so a stale word cannot pass for a fresh one
            fetch_word <= go ? mem[rd_nxt] : ~fetch_word;
        end
    end
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the instruction format decoder
// Assumes: fetch model supplies words in program order; bench drives redirects
// Notes: every scenario starts and ends at a falling edge so pushes never race the model
`timescale 1ns/1ns
module tb_top
    import dscifd_pkg::*;
;
    logic core_clk;
    logic sys_rst;
    logic exec_redirect;
    logic run;
    logic fetch_valid, fetch_ready, dec_valid, dec_nop, dec_two_word, dec_second_bad;
    logic dec_dest_is_file, dec_bit_from_reg, dec_target_is_file, dec_acc_sel;
    logic [23:0] fetch_word;
    logic [15:0] dec_ext_word, dec_literal;
    dscifd_cat_t dec_cat;
    logic [7:0] dec_opcode;
    logic [3:0] base_work_reg, source_work_reg, dest_work_reg, dec_bit_pos;
    logic [1:0] dec_src_mode, dec_dest_mode, dec_x_op, dec_x_dst, dec_y_op, dec_y_dst, dec_awb;
    logic [12:0] dec_file_addr;
    logic [2:0] dec_mul_pair;
    int errors = 0;
    int cmp_count = 0;
    logic [13:0] mon_q [$];
    dscifd_decoder dut (.core_clk, .sys_rst, .fetch_valid, .fetch_word, .fetch_ready, .exec_redirect, .dec_valid,
        .dec_nop, .dec_two_word, .dec_second_bad, .dec_ext_word, .dec_cat, .dec_opcode, .base_work_reg,
        .source_work_reg, .dec_src_mode, .dest_work_reg, .dec_dest_mode, .dec_file_addr, .dec_dest_is_file,
        .dec_bit_pos, .dec_bit_from_reg, .dec_target_is_file, .dec_literal, .dec_acc_sel, .dec_mul_pair,
        .dec_x_op, .dec_x_dst, .dec_y_op, .dec_y_dst, .dec_awb);
    dscifd_fetch_model fm (.core_clk, .sys_rst, .run, .fetch_ready, .fetch_valid, .fetch_word);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (dec_valid === 1'b1) begin
            mon_q.push_back({dec_cat, dec_nop, dec_two_word, dec_second_bad, dec_opcode});
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic drain(input int n);
        for (int k = 0; k < 40 && mon_q.size() < n; k++) @(posedge core_clk);
        if (mon_q.size() < n) begin
            errors++;
            $display("[FAIL] decode count expected %0d seen %0d", n, mon_q.size());
            wrap_up();
        end
        @(negedge core_clk);
    endtask
    task automatic pop(input logic [13:0] e);
        chk("decode entry", {2'b00, mon_q.pop_front()}, {2'b00, e});
    endtask
    task automatic one(input logic [23:0] w, input dscifd_cat_t c);
        fm.push(w);
        drain(1);
        pop({c, 3'b000, w[23:16]});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("fetch_ready", fetch_ready, 1'b1);
        chk("dec_valid", dec_valid, 1'b0);
        chk("dec_cat", dec_cat, 3'h0);
        $display("test reset done");
    endtask
    task automatic t_fields();
        one(24'h4A3567, DSCIFD_CAT_WORD_BYTE);
        chk("default_work_reg ops", {base_work_reg, dec_dest_mode, dest_work_reg, dec_src_mode, source_work_reg}, 16'h3567);
        one(24'h853ABC, DSCIFD_CAT_WORD_BYTE);
        chk("file addr", dec_file_addr, 13'h1ABC);
        chk("file dest", {dec_dest_is_file, dest_work_reg}, {1'b1, DEFAULT_WORK_REG});
        one(24'hA39555, DSCIFD_CAT_BIT);
        chk("bit sel", {dec_bit_pos, dec_bit_from_reg, dec_target_is_file}, 6'h25);
        chk("bit file", dec_file_addr, 13'h0155);
        one(24'hA27826, DSCIFD_CAT_BIT);
        chk("bit reg", {base_work_reg, dec_bit_pos, dec_bit_from_reg, dec_target_is_file, dec_src_mode, source_work_reg}, 16'h70A6);
        one(24'h10ABCD, DSCIFD_CAT_LITERAL);
        chk("move lit", dec_literal, 16'h0ABC);
        chk("move reg", base_work_reg, 4'hD);
        one(24'h11A53C, DSCIFD_CAT_LITERAL);
        chk("file lit", dec_literal, 16'h00A5);
        chk("move file", dec_file_addr, 13'h003C);
        one(24'h205AC0, DSCIFD_CAT_LITERAL);
        chk("arith same dest", {base_work_reg, dec_dest_mode, dest_work_reg}, 10'h145);
        chk("arith same lit", dec_literal, 16'h002B);
        one(24'h212AB6, DSCIFD_CAT_LITERAL);
        chk("arith ops", {base_work_reg, dec_dest_mode, dest_work_reg}, 10'h0B6);
        chk("arith lit", dec_literal, 16'h002A);
        one(24'hC4D9E4, DSCIFD_CAT_DSP);
        chk("mac ops", {dec_acc_sel, dec_mul_pair, dec_x_op, dec_x_dst, dec_y_op, dec_y_dst, dec_awb}, 14'h3679);
        one(24'hD71234, DSCIFD_CAT_CONTROL);
        chk("ctrl lit", dec_literal, 16'h1234);
        $display("test fields done");
    endtask
    task automatic t_stream();
        run = 1'b0;
        fm.push(24'h4A3567);
        fm.push(24'h020011);
        fm.push(24'h00BEEF);
        fm.push(24'h000000);
        fm.push(24'hD00000);
        fm.push(24'h041111);
        fm.push(24'h12ABCD);
        @(negedge core_clk);
        run = 1'b1;
        repeat (3) @(negedge core_clk);
        run = 1'b0;
        repeat (2) @(negedge core_clk);
        run = 1'b1;
        drain(5);
        pop({DSCIFD_CAT_WORD_BYTE, 3'b000, 8'h4A});
        pop({DSCIFD_CAT_CONTROL, 3'b010, 8'h02});
        pop({DSCIFD_CAT_CONTROL, 3'b100, 8'h00});
        pop({DSCIFD_CAT_CONTROL, 3'b000, 8'hD0});
        pop({DSCIFD_CAT_CONTROL, 3'b011, 8'h04});
        chk("pair words", dec_ext_word, 16'hABCD);
        chk("first literal", dec_literal, 16'h1111);
        $display("test stream done");
    endtask
    task automatic t_redirect();
        fm.push(24'h060001);
        for (int k = 0; k < 20 && fetch_valid !== 1'b1; k++) @(posedge core_clk);
        if (fetch_valid !== 1'b1) begin
            chk("word offered", fetch_valid, 1'b1);
            wrap_up();
        end
        @(posedge core_clk);
        exec_redirect <= 1'b1;
        @(posedge core_clk);
        exec_redirect <= 1'b0;
        @(negedge core_clk);
        chk("ready after redirect", fetch_ready, 1'b0);
        fm.push(24'h4A3567);
        drain(2);
        pop({DSCIFD_CAT_CONTROL, 3'b100, 8'h00});
        pop({DSCIFD_CAT_WORD_BYTE, 3'b000, 8'h4A});
        $display("test redirect done");
    endtask
    initial begin
        sys_rst = 1'b1;
        exec_redirect = 1'b0;
        run = 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        t_reset();
        t_fields();
        t_stream();
        t_redirect();
        wrap_up();
    end
endmodule
bind dscifd_decoder dscifd_decoder_assertions chk_i (.core_clk, .sys_rst, .fetch_valid, .fetch_word, .fetch_ready,
    .exec_redirect, .dec_valid, .dec_nop, .dec_two_word, .dec_second_bad, .dec_ext_word, .dec_cat, .dec_opcode,
    .dec_literal);
